// *** ccr_bank.sv ***
// Purpose: Configuration register bank written over the serial control port
// Assumes: Serial pins sampled as synchronous inputs of clk_i
// Notes:   Write-only port; the configuration is visible on cfg_o
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Writing one to offset 0x00 bit 0 restores all defaults, bit self-clears.
// - Writes are accepted and stored even while powered down.
// - Offset 0x31 bits 2:0 pick one, two or four channels; four default.
// - Branches per channel: two in four-channel, four in two, eight in one.
// - Two-channel: cores 1,2 form channel 1, cores 3,4 channel 2.
// - Offset 0x31 bits 9:8 divide the input clock by 1, 2, 4 or 8.
// - Route fields: 0x3A bits 4:0 and 12:8, 0x3B bits 4:0 and 12:8.
// - Route codes one-hot in bits 4:1 select inputs one to four.
// - Route changes apply at end of command, no power cycle needed.
// - Offset 0x55 bits 5:0 hold the monotonic full-scale trim code.
// - Offset 0x53 bit 4 brings the frame output one clock earlier when bit 5 is clear.
// - Offset 0x53 bit 5 brings the frame output one clock later when bit 4 is clear.
// - Offset 0x53 bit 3 flags a low input clock frequency.
// - Offset 0x56 bits 2:0 choose the wake-up delay in sample clocks.
module ccr_bank (
  // Clock and reset
  input  wire logic              clk_i,
  input  wire logic              rst_b_i,
  // Serial control port
  input  wire logic              ser_clk_i,
  input  wire logic              ser_data_i,
  input  wire logic              ser_sel_b_i,
  // Power-down level
  input  wire logic              power_down_i,
  // Configuration and derived controls
  output var  ccr_pkg::ccr_cfg_t cfg_o,
  output logic                   sample_en_o,
  output logic                   frame_o,
  output logic [3:0]             branches_o,
  output logic [7:0]             core_channel_o,
  output logic [7:0]             core_input_sel_o,
  output logic                   ready_o,
  output logic                   reconfig_pending_o
);
  import ccr_pkg::*;

  ccr_ser_state_t  state;
  logic            sclk_q;
  logic [23:0]     shift;
  logic [4:0]      bit_cnt;
  logic [2:0]      div_cnt;
  logic [2:0]      div_max;
  logic            tick;
  logic [1:0]      tick_q;
  logic [13:0]     wake_cnt;
  logic [7:0]      cmd_addr;
  logic [15:0]     cmd_data;
  logic            commit;

  assign cmd_addr = shift[ADDR_MSB:ADDR_LSB];
  assign cmd_data = shift[15:0];
  assign commit   = (state == SER_COMMIT);

  function automatic logic [1:0] route_index(input logic [4:0] code, input logic [1:0] hold);
    unique case (code)
      ROUTE_IN1: route_index = 2'h0;
      ROUTE_IN2: route_index = 2'h1;
      ROUTE_IN3: route_index = 2'h2;
      ROUTE_IN4: route_index = 2'h3;
      default:   route_index = hold;
    endcase
  endfunction

  function automatic logic [13:0] wake_cycles(input logic [2:0] sel, input logic [2:0] chan);
    logic [13:0] base;
    base = WAKE_CYC_100;
    unique case (sel)
      3'h0:    base = WAKE_CYC_000;
      3'h1:    base = WAKE_CYC_001;
      3'h5:    base = WAKE_CYC_101;
      3'h3:    base = WAKE_CYC_011;
      default: base = WAKE_CYC_100;
    endcase
    // Wider interleave runs the same wall time at a faster sample clock
    if (chan == CHAN_ONE)
      wake_cycles = base << 2;
    else if (chan == CHAN_TWO)
      wake_cycles = base << 1;
    else
      wake_cycles = base;
  endfunction

  // Pin sampling for edge detection
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sclk_q <= 1'b0;
    end
    else
    begin
      sclk_q <= ser_clk_i;
    end
  end

  // Serial command receiver; short or long frames are dropped whole
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state   <= SER_IDLE;
      shift   <= 24'h000000;
      bit_cnt <= 5'h00;
    end
    else
    begin
      unique case (state)
        SER_IDLE:
        begin
          bit_cnt <= 5'h00;
          if (!ser_sel_b_i)
            state <= SER_SHIFT;
        end
        SER_SHIFT:
        begin
          if (ser_clk_i && !sclk_q && !ser_sel_b_i)
          begin
            shift <= {shift[22:0], ser_data_i};
            if (bit_cnt != 5'h1F)
              bit_cnt <= bit_cnt + 5'h01;
          end
          if (ser_sel_b_i)
            state <= (bit_cnt == 5'(FRAME_BITS)) ? SER_COMMIT : SER_IDLE;
        end
        SER_COMMIT:
          state <= SER_IDLE;
      endcase
    end
  end

  // Register file
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      cfg_o <= CFG_RST;
    else if (commit)
    begin
      unique case (cmd_addr)
        OFS_SOFTWARE_RESET:
          if (cmd_data[SWRST_BIT])
            cfg_o <= CFG_RST;
        OFS_MODE_CLKDIV:
        begin
          cfg_o.chan_num <= cmd_data[CHAN_LSB +: 3];
          cfg_o.clk_div  <= cmd_data[CLKDIV_LSB +: 2];
        end
        OFS_ROUTE_12:
        begin
          cfg_o.core_one_input_route <= {cmd_data[ROUTE_LO+1 +: 4], 1'b0};
          cfg_o.core_two_input_route <= {cmd_data[ROUTE_HI+1 +: 4], 1'b0};
        end
        OFS_ROUTE_34:
        begin
          cfg_o.core_three_input_route <= {cmd_data[ROUTE_LO+1 +: 4], 1'b0};
          cfg_o.core_four_input_route  <= {cmd_data[ROUTE_HI+1 +: 4], 1'b0};
        end
        OFS_OUT_TIMING:
        begin
          cfg_o.low_clk     <= cmd_data[LOWCLK_BIT];
          cfg_o.out_advance <= cmd_data[ADVANCE_BIT];
          cfg_o.out_delay   <= cmd_data[DELAY_BIT];
        end
        OFS_FS_TRIM:
          cfg_o.full_scale_trim_code <= cmd_data[TRIM_LSB +: 6];
        OFS_WAKEUP_DELAY:
          cfg_o.wake_sel <= cmd_data[WAKE_LSB +: 3];
        default:
          cfg_o <= cfg_o;
      endcase
    end
  end

  // Channel mode decode; an illegal multi-bit code keeps the last mode
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      branches_o     <= BRANCH_FOUR_CH;
      core_channel_o <= 8'hE4;
    end
    else
    begin
      if (cfg_o.chan_num == CHAN_FOUR)
      begin
        branches_o     <= BRANCH_FOUR_CH;
        core_channel_o <= 8'hE4;
      end
      else if (cfg_o.chan_num == CHAN_TWO)
      begin
        branches_o     <= BRANCH_TWO_CH;
        core_channel_o <= 8'h50;
      end
      else if (cfg_o.chan_num == CHAN_ONE)
      begin
        branches_o     <= BRANCH_ONE_CH;
        core_channel_o <= 8'h00;
      end
    end
  end

  // Cross-point selection; a forbidden code keeps the previous input
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      core_input_sel_o <= 8'hE4;
    else
    begin
      core_input_sel_o[1:0] <= route_index(cfg_o.core_one_input_route, core_input_sel_o[1:0]);
      core_input_sel_o[3:2] <= route_index(cfg_o.core_two_input_route, core_input_sel_o[3:2]);
      core_input_sel_o[5:4] <= route_index(cfg_o.core_three_input_route, core_input_sel_o[5:4]);
      core_input_sel_o[7:6] <= route_index(cfg_o.core_four_input_route, core_input_sel_o[7:6]);
    end
  end

  // Sample-rate divider
  assign div_max = 3'((4'h1 << cfg_o.clk_div) - 4'h1);
  assign tick    = (div_cnt >= div_max);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      div_cnt     <= 3'h0;
      sample_en_o <= 1'b0;
    end
    else
    begin
      div_cnt     <= tick ? 3'h0 : div_cnt + 3'h1;
      sample_en_o <= tick;
    end
  end

  // Frame timing: nominal two clocks after the tick, advance one, delay three
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      tick_q  <= 2'h0;
      frame_o <= 1'b0;
    end
    else
    begin
      tick_q <= {tick_q[0], tick};
      if (cfg_o.out_advance && !cfg_o.out_delay)
        frame_o <= tick;
      else if (cfg_o.out_delay && !cfg_o.out_advance)
        frame_o <= tick_q[1];
      else
        frame_o <= tick_q[0];
    end
  end

  // Wake-up counter, counted in sample clocks after power-down release
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wake_cnt <= WAKE_CYC_000;
      ready_o  <= 1'b0;
    end
    else if (power_down_i)
    begin
      wake_cnt <= wake_cycles(cfg_o.wake_sel, cfg_o.chan_num);
      ready_o  <= 1'b0;
    end
    else
    begin
      if (tick && wake_cnt != 14'h0000)
        wake_cnt <= wake_cnt - 14'h0001;
      ready_o <= (wake_cnt == 14'h0000);
    end
  end

  // Settings that only take hold after a power cycle; the cycle clears it
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      reconfig_pending_o <= 1'b0;
    else if (power_down_i)
      reconfig_pending_o <= 1'b0;
    else if (commit && (cmd_addr == OFS_MODE_CLKDIV || cmd_addr == OFS_WAKEUP_DELAY
             || cmd_addr == OFS_OUT_TIMING))
      reconfig_pending_o <= 1'b1;
  end

  sequence s_write(logic [7:0] ofs);
    commit && cmd_addr == ofs;
  endsequence
  sequence s_route_lands;
    ##1 cfg_o.core_one_input_route == $past(cmd_data[4:0])
    ##1 (cfg_o.core_one_input_route != ROUTE_IN2 || core_input_sel_o[1:0] == 2'h1);
  endsequence

  AST_SOFT_RESET: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_write(OFS_SOFTWARE_RESET) ##0 cmd_data[0] |=> cfg_o == CFG_RST)
    else $error("soft reset did not restore defaults");
  AST_CHAN_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_write(OFS_MODE_CLKDIV) |=> cfg_o.chan_num == $past(cmd_data[2:0])
      && cfg_o.clk_div == $past(cmd_data[9:8]))
    else $error("mode write not stored");
  AST_BRANCHES: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    cfg_o.chan_num == CHAN_TWO |=> branches_o == BRANCH_TWO_CH && core_channel_o[5:4] == 2'h1)
    else $error("two-channel branch count or mapping wrong");
  AST_DIV_EIGHT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    sample_en_o && cfg_o.clk_div == 2'h3 && $past(cfg_o.clk_div) == 2'h3
      |=> (!sample_en_o || cfg_o.clk_div != 2'h3)[*7])
    else $error("divide-by-eight tick spacing wrong");
  AST_ROUTE_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_write(OFS_ROUTE_12) |-> s_route_lands)
    else $error("route write not applied at end of command");
  AST_FRAME_NOMINAL: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    (tick && !cfg_o.out_advance && !cfg_o.out_delay)
      ##1 (!cfg_o.out_advance && !cfg_o.out_delay) |=> frame_o)
    else $error("nominal frame timing wrong");
  AST_PD_WRITE: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    s_write(OFS_FS_TRIM) ##0 power_down_i |=> cfg_o.full_scale_trim_code == $past(cmd_data[5:0]))
    else $error("write lost during power-down");
  AST_WAKE_WAIT: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    $fell(power_down_i) |-> (!ready_o)[*8])
    else $error("ready before wake-up delay");
  AST_CFG_HOLD: assert property (@(posedge clk_i) disable iff (!rst_b_i)
    !commit |=> $stable(cfg_o))
    else $error("configuration changed without a write");

endmodule
`default_nettype wire

// *** ccr_pkg.sv ***
// Purpose: Shared constants and types of the converter configuration bank
// Assumes: 24-bit serial command, 8-bit offset then 16-bit data, MSB first
// Notes:   Offsets, field positions, cfg_o reset values and counts live here; decode output resets are literals except branches_o
package ccr_pkg;

  // Serial command layout
  localparam int unsigned FRAME_BITS = 24;
  localparam int unsigned ADDR_MSB   = 23;
  localparam int unsigned ADDR_LSB   = 16;

  // Register offsets
  localparam logic [7:0] OFS_SOFTWARE_RESET = 8'h00;
  localparam logic [7:0] OFS_MODE_CLKDIV    = 8'h31;
  localparam logic [7:0] OFS_ROUTE_12       = 8'h3A;
  localparam logic [7:0] OFS_ROUTE_34       = 8'h3B;
  localparam logic [7:0] OFS_OUT_TIMING     = 8'h53;
  localparam logic [7:0] OFS_FS_TRIM        = 8'h55;
  localparam logic [7:0] OFS_WAKEUP_DELAY   = 8'h56;

  // Field positions
  localparam int unsigned SWRST_BIT   = 0;
  localparam int unsigned CHAN_LSB    = 0;
  localparam int unsigned CLKDIV_LSB  = 8;
  localparam int unsigned ROUTE_LO    = 0;
  localparam int unsigned ROUTE_HI    = 8;
  localparam int unsigned LOWCLK_BIT  = 3;
  localparam int unsigned ADVANCE_BIT = 4;
  localparam int unsigned DELAY_BIT   = 5;
  localparam int unsigned TRIM_LSB    = 0;
  localparam int unsigned WAKE_LSB    = 0;

  // Channel-count codes
  localparam logic [2:0] CHAN_ONE  = 3'h1;
  localparam logic [2:0] CHAN_TWO  = 3'h2;
  localparam logic [2:0] CHAN_FOUR = 3'h4;

  // Routing codes, lowest bit always zero
  localparam logic [4:0] ROUTE_IN1 = 5'h02;
  localparam logic [4:0] ROUTE_IN2 = 5'h04;
  localparam logic [4:0] ROUTE_IN3 = 5'h08;
  localparam logic [4:0] ROUTE_IN4 = 5'h10;

  // Reset values
  localparam logic [1:0] CLKDIV_RST = 2'h0;
  localparam logic [5:0] TRIM_RST   = 6'h00;
  localparam logic [2:0] WAKE_RST   = 3'h0;

  // Interleaved branches per channel
  localparam logic [3:0] BRANCH_FOUR_CH = 4'h2;
  localparam logic [3:0] BRANCH_TWO_CH  = 4'h4;
  localparam logic [3:0] BRANCH_ONE_CH  = 4'h8;

  // Wake-up delay, sample clocks, in four-channel mode
  localparam logic [13:0] WAKE_CYC_100 = 14'h0C00;
  localparam logic [13:0] WAKE_CYC_000 = 14'h07C0;
  localparam logic [13:0] WAKE_CYC_001 = 14'h0500;
  localparam logic [13:0] WAKE_CYC_101 = 14'h0348;
  localparam logic [13:0] WAKE_CYC_011 = 14'h0208;

  typedef struct packed {
    logic [2:0] chan_num;
    logic [1:0] clk_div;
    logic [4:0] core_one_input_route;
    logic [4:0] core_two_input_route;
    logic [4:0] core_three_input_route;
    logic [4:0] core_four_input_route;
    logic       low_clk;
    logic       out_advance;
    logic       out_delay;
    logic [5:0] full_scale_trim_code;
    logic [2:0] wake_sel;
  } ccr_cfg_t;

  localparam ccr_cfg_t CFG_RST = '{
    chan_num:               CHAN_FOUR,
    clk_div:                CLKDIV_RST,
    core_one_input_route:   ROUTE_IN1,
    core_two_input_route:   ROUTE_IN2,
    core_three_input_route: ROUTE_IN3,
    core_four_input_route:  ROUTE_IN4,
    low_clk:                1'b0,
    out_advance:            1'b0,
    out_delay:              1'b0,
    full_scale_trim_code:   TRIM_RST,
    wake_sel:               WAKE_RST
  };

  typedef enum logic [2:0] {
    SER_IDLE   = 3'b001,
    SER_SHIFT  = 3'b010,
    SER_COMMIT = 3'b100
  } ccr_ser_state_t;

endpackage

// *** ccr_host.sv ***
// Purpose: Serial control host model for the configuration bank
// Assumes: Requests seen on rising clk_i, pins moved on falling clk_i
// Notes:   Deselected data line shows the inverted last bit
`timescale 1ns/1ps
`default_nettype none
module ccr_host
(
  // Clock
  input  wire logic        clk_i,
  // Request
  input  wire logic        req_i,
  input  wire logic        slow_i,
  input  wire logic [4:0]  nbits_i,
  input  wire logic [7:0]  ofs_i,
  input  wire logic [15:0] data_i,
  // Serial pins and busy flag
  output logic             sclk_o,
  output logic             sdat_o,
  output logic             sel_b_o,
  output logic             busy_o
);
  import ccr_pkg::*;
  logic [23:0] word;
  int          half;

  // Defined bits only; zero marks an offset never sent
  function automatic logic [15:0] mask(input logic [7:0] o);
    case (o)
      OFS_SOFTWARE_RESET: return 16'h0001;
      OFS_MODE_CLKDIV:    return 16'h0307;
      OFS_ROUTE_12:       return 16'h1E1E;
      OFS_ROUTE_34:       return 16'h1E1E;
      OFS_OUT_TIMING:     return 16'h0038;
      OFS_FS_TRIM:        return 16'h003F;
      OFS_WAKEUP_DELAY:   return 16'h0007;
      default:            return 16'h0000;
    endcase
  endfunction

  initial
  begin
    sclk_o  = 1'b0;
    sdat_o  = 1'b0;
    sel_b_o = 1'b1;
    busy_o  = 1'b0;
    forever
    begin
      @(posedge clk_i);
      if (req_i === 1'b1 && mask(ofs_i) != 16'h0000)
      begin
        busy_o = 1'b1;
        word   = {ofs_i, data_i & mask(ofs_i)};
        half   = slow_i ? 4 : 2;
        @(negedge clk_i);
        sel_b_o = 1'b0;
        for (int i = 0; i < nbits_i; i++)
        begin
          sdat_o = word[23 - i];
          repeat (half) @(negedge clk_i);
          sclk_o = 1'b1;
          repeat (half) @(negedge clk_i);
          sclk_o = 1'b0;
        end
        repeat (half) @(negedge clk_i);
        sel_b_o = 1'b1;
        sdat_o  = ~sdat_o;
        repeat (4) @(negedge clk_i);
        busy_o = 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** converter_config_register_bank_bench.sv ***
// Purpose: Self-checking bench of the configuration bank
// Assumes: Host model drives the serial pins, bench drives power-down
// Notes:   Mode and divider scaling stretch wake-up waits up to eightfold; run stays near 60k cycles
`timescale 1ns/1ps
`default_nettype none
module converter_config_register_bank_bench;
  import ccr_pkg::*;
  logic       clk_i, rst_b_i, pd, req, slow, sclk, sdat, sel_b, busy;
  logic [4:0] nbits;
  logic [7:0] ofs;
  logic [15:0] wdat;
  ccr_cfg_t   cfg, ex;
  logic       sen, frm, rdy, pend;
  logic [3:0] br;
  logic [7:0] cch, csel, hist;
  logic [2:0] c, code;
  logic [1:0] d;
  logic [1:0] ix [4];
  int         err_count, n_tests, cyc, k, lag;
  localparam logic [17:0] WTAB = {3'h7, 3'h3, 3'h5, 3'h1, 3'h0, 3'h4};

  ccr_host host_u (.clk_i(clk_i), .req_i(req), .slow_i(slow), .nbits_i(nbits), .ofs_i(ofs),
    .data_i(wdat), .sclk_o(sclk), .sdat_o(sdat), .sel_b_o(sel_b), .busy_o(busy));
  ccr_bank dut_u (.clk_i(clk_i), .rst_b_i(rst_b_i), .ser_clk_i(sclk), .ser_data_i(sdat),
    .ser_sel_b_i(sel_b), .power_down_i(pd), .cfg_o(cfg), .sample_en_o(sen), .frame_o(frm),
    .branches_o(br), .core_channel_o(cch), .core_input_sel_o(csel), .ready_o(rdy),
    .reconfig_pending_o(pend));

  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  // Wake-up count per code, scaled by mode and divider
  function automatic int wake_n(input logic [2:0] w, input logic [2:0] ch, input logic [1:0] dv);
    int n;
    case (w)
      3'h0: n = 1984;
      3'h1: n = 1280;
      3'h5: n = 840;
      3'h3: n = 520;
      default: n = 3072;
    endcase
    if (ch == CHAN_TWO) n = n * 2;
    if (ch == CHAN_ONE) n = n * 4;
    return n << dv;
  endfunction

  task automatic fail(input string m);
    err_count++;
    $display("mismatch t=%0t %s", $time, m);
  endtask
  task automatic chk_cfg(input string m);
    n_tests++;
    if (cfg !== ex) fail(m);
  endtask
  task automatic chk8(input logic [7:0] g, input logic [7:0] e, input string m);
    n_tests++;
    if (g !== e) fail(m);
  endtask
  task automatic chk_rng(input int g, input int lo, input int hi, input string m);
    n_tests++;
    if (g < lo || g > hi) fail(m);
  endtask
  task automatic conclude();
    $display("compares %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  task automatic wr(input logic [7:0] o, input logic [15:0] v, input logic [4:0] nb = 5'h18);
    int n;
    @(negedge clk_i);
    ofs   = o;
    wdat  = v;
    nbits = nb;
    slow  = 1'($urandom % 2);
    req   = 1'b1;
    @(negedge clk_i);
    req = 1'b0;
    n = 0;
    while (busy !== 1'b0 && n < 1000)
    begin
      @(negedge clk_i);
      n++;
    end
    @(negedge clk_i);
  endtask
  // Divider phase at release shifts the first tick by up to one sample period
  task automatic wait_ready(input int e, input int dv, input string m);
    int n;
    n = 0;
    while (rdy !== 1'b1 && n < 40000)
    begin
      @(negedge clk_i);
      n++;
    end
    chk_rng(n, e + 1 - (1 << dv), e + 4, m);
  endtask
  task automatic pd_enter();
    @(negedge clk_i);
    pd = 1'b1;
    repeat (4) @(negedge clk_i);
  endtask
  task automatic pd_leave(input int e, input int dv = 0);
    chk8({7'h00, rdy}, 8'h00, "ready in power down");
    chk8({7'h00, pend}, 8'h00, "pending in power down");
    pd = 1'b0;
    wait_ready(e, dv, "wake-up length");
  endtask

  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc == 90000)
    begin
      fail("timeout");
      conclude();
    end
  end

  initial
  begin
    rst_b_i = 1'b0;
    {pd, req, slow} = 3'h0;
    nbits = 5'h18;
    ofs = 8'h00;
    wdat = 16'h0000;
    {err_count, n_tests} = {32'h0, 32'h0};
    void'($urandom(43827));
    ex = CFG_RST;
    repeat (8) @(negedge clk_i);
    rst_b_i = 1'b1;
    chk_cfg("defaults");
    chk8({4'h0, br}, 8'h02, "default branches");
    chk8(cch, 8'hE4, "default channels");
    chk8(csel, 8'hE4, "default routes");
    wait_ready(1984, 0, "ready after reset");
    $display("test defaults done");
    for (int m = 0; m < 4; m++)
    begin
      c = (m == 0) ? CHAN_ONE : (m == 1) ? CHAN_TWO : CHAN_FOUR;
      // Divide by eight once; the last pass leaves divide by four for the frame test
      d = (m == 2) ? 2'h3 : (m == 3) ? 2'h2 : 2'(m);
      wr(OFS_MODE_CLKDIV, {6'h00, d, 5'h00, c});
      ex.chan_num = c;
      ex.clk_div  = d;
      chk_cfg("mode write");
      chk8({7'h00, pend}, 8'h01, "pending after mode");
      chk8({4'h0, br}, (m == 0) ? 8'h08 : (m == 1) ? 8'h04 : 8'h02, "branches");
      chk8(cch, (m == 0) ? 8'h00 : (m == 1) ? 8'h50 : 8'hE4, "core channels");
      pd_enter();
      pd_leave(wake_n(WAKE_RST, c, d), d);
      k = 0;
      repeat (16)
      begin
        @(negedge clk_i);
        if (sen === 1'b1) k++;
      end
      chk_rng(k, 16 >> d, 16 >> d, "sample rate");
    end
    $display("test modes done");
    for (int r = 0; r < 4; r++)
    begin
      foreach (ix[i]) ix[i] = (r == 0) ? 2'h3 : 2'($urandom % 4);
      ex.core_one_input_route   = ROUTE_IN1 << ix[0];
      ex.core_two_input_route   = ROUTE_IN1 << ix[1];
      ex.core_three_input_route = ROUTE_IN1 << ix[2];
      ex.core_four_input_route  = ROUTE_IN1 << ix[3];
      wr(OFS_ROUTE_12, {3'h0, ex.core_two_input_route, 3'h0, ex.core_one_input_route});
      wr(OFS_ROUTE_34, {3'h0, ex.core_four_input_route, 3'h0, ex.core_three_input_route});
      chk_cfg("route write");
      chk8(csel, {ix[3], ix[2], ix[1], ix[0]}, "route decode");
      chk8({7'h00, pend}, 8'h00, "route needs no power cycle");
    end
    $display("test routes done");
    for (int a = 0; a < 4; a++)
    begin
      wr(OFS_OUT_TIMING, 16'(a) << 4);
      ex.out_advance = a[0];
      ex.out_delay   = a[1];
      chk_cfg("timing write");
      k = 0;
      hist = 8'h00;
      while (!(k >= 8 && frm === 1'b1) && k < 64)
      begin
        hist = {hist[6:0], sen};
        @(negedge clk_i);
        k++;
      end
      lag = (a == 1) ? 1 : (a == 2) ? 3 : 2;
      // Lag counts from the tick; sample enable trails it by one, period four
      chk8({4'h0, hist[3:0]}, 8'h01 << ((lag + 2) % 4), "frame lag");
    end
    $display("test timing done");
    wr(OFS_SOFTWARE_RESET, 16'h0000);
    wr(OFS_FS_TRIM, 16'h0015, 5'h14);
    chk_cfg("zero reset and short frame");
    wr(OFS_SOFTWARE_RESET, 16'h0001);
    ex = CFG_RST;
    chk_cfg("software reset");
    wr(OFS_OUT_TIMING, 16'h0000);
    chk_cfg("reset bit cleared");
    pd_enter();
    ex.full_scale_trim_code = 6'($urandom);
    ex.low_clk = 1'b1;
    wr(OFS_FS_TRIM, {10'h000, ex.full_scale_trim_code});
    wr(OFS_OUT_TIMING, 16'h0008);
    chk_cfg("writes in power down");
    pd_leave(1984);
    $display("test reset and power down done");
    for (int w = 0; w < 6; w++)
    begin
      code = WTAB[3 * w +: 3];
      wr(OFS_WAKEUP_DELAY, {13'h0000, code});
      ex.wake_sel = code;
      chk_cfg("wake code write");
      pd_enter();
      pd_leave(wake_n(code, CHAN_FOUR, 2'h0));
    end
    $display("test wake-up done");
    conclude();
  end
endmodule
`default_nettype wire
